/* File: rtl/rx_bit_collision_pkg.sv */
// constants for the receive bit control and collision status block
// assumes a byte-wide register port and a single system clock
package rx_bit_collision_pkg;
   localparam logic [7:0] comm_status_addr = 8'h0b;
   localparam logic [7:0] rx_bit_control_addr = 8'h0c;
   localparam logic [7:0] rx_collision_info_addr = 8'h0d;
   localparam int cipher_bit = 5;
   localparam int keep_bit = 7;
   localparam int align_lsb = 4;
   localparam int clash_err_bit = 3;
   localparam int valid_bit = 7;
   localparam logic [7:0] rx_bit_control_reset = 8'h00;
   localparam logic [6:0] clash_pos_max = 7'h3f;
   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_tx_wait = 3'b001,
      st_transmit = 3'b011,
      st_rx_wait = 3'b101,
      st_wait_data = 3'b110,
      st_receive = 3'b111
   } comm_state_t;
endpackage

/* File: rtl/rx_bit_collision_status.sv */
// register bank for transceiver status, bit alignment and collision capture
// assumes the framing engine drives state, bit strobes and frame events
`timescale 1ns/1ns
module rx_bit_collision_status (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // framing engine
   input wire logic [2:0] comm_fsm_state,
   input wire logic card_authenticate_cmd,
   input wire logic rx_start,
   input wire logic rx_bit_valid,
   input wire logic rx_bit,
   input wire logic rx_bit_clash,
   input wire logic rx_end,
   // stored data and flags
   output logic cipher_active,
   output logic [7:0] rx_byte,
   output logic rx_byte_valid,
   output logic clash_detected,
   output logic integrity_error
);
   logic cipher_q, cipher_d;
   logic [7:0] ctrl_q, ctrl_d;
   logic [6:0] pos_q, pos_d;
   logic pos_valid_q, pos_valid_d;
   logic clash_seen_q, clash_seen_d;
   logic [9:0] bit_idx_q, bit_idx_d;
   logic [7:0] byte_q, byte_d;
   logic byte_valid_q, byte_valid_d;
   logic clash_flag_q, clash_flag_d;
   logic integ_q, integ_d;
   logic [7:0] rdata_q, rdata_d;
   logic [2:0] align;
   logic [2:0] slot;
   logic data_bit;
   logic wr_status, wr_ctrl;

   // declared ahead of its first use below
   localparam int align_lsb = rx_bit_collision_pkg::align_lsb;

   assign align = ctrl_q[align_lsb +: 3];
   assign slot = bit_idx_q[2:0];
   assign wr_status = reg_wr && reg_addr == rx_bit_collision_pkg::comm_status_addr;
   assign wr_ctrl = reg_wr && reg_addr == rx_bit_collision_pkg::rx_bit_control_addr;

   always_comb begin
      cipher_d = cipher_q;
      ctrl_d = ctrl_q;
      pos_d = pos_q;
      pos_valid_d = pos_valid_q;
      clash_seen_d = clash_seen_q;
      bit_idx_d = bit_idx_q;
      byte_d = byte_q;
      byte_valid_d = 1'b0;
      clash_flag_d = clash_flag_q;
      integ_d = integ_q;
      data_bit = rx_bit;
      // clear by software; authentication set wins
      if (wr_status && !reg_wdata[rx_bit_collision_pkg::cipher_bit]) begin
         cipher_d = 1'b0;
      end
      if (card_authenticate_cmd) begin
         cipher_d = 1'b1;
      end
      if (wr_ctrl) begin
         // last-bits field is owned by the decoder
         ctrl_d[7:3] = reg_wdata[7:3];
      end
      if (rx_start) begin
         ctrl_d[2:0] = 3'h0;
         pos_d = 7'h00;
         pos_valid_d = 1'b0;
         clash_seen_d = 1'b0;
         clash_flag_d = 1'b0;
         integ_d = 1'b0;
         // alignment offsets the first stored slot
         bit_idx_d = {7'h00, align};
         byte_d = 8'h00;
      end else if (rx_bit_valid) begin
         if ((clash_seen_q || rx_bit_clash) &&
             !ctrl_q[rx_bit_collision_pkg::keep_bit]) begin
            data_bit = 1'b0;
         end
         if (rx_bit_clash && !clash_seen_q) begin
            clash_seen_d = 1'b1;
            clash_flag_d = 1'b1;
            // index counts stored slots, so alignment is included
            if (bit_idx_q <= {3'h0, rx_bit_collision_pkg::clash_pos_max}) begin
               pos_d = bit_idx_q[6:0];
               pos_valid_d = 1'b1;
            end
         end
         if (rx_bit_clash && ctrl_q[rx_bit_collision_pkg::clash_err_bit]) begin
            integ_d = 1'b1;
         end
         byte_d[slot] = data_bit;
         bit_idx_d = bit_idx_q + 10'h001;
         if (slot == 3'h7) begin
            byte_valid_d = 1'b1;
            byte_d = 8'h00;
         end
      end else if (rx_end) begin
         if (align != 3'h0) begin
            ctrl_d[2:0] = slot;
         end
      end
      if (rx_end && slot != 3'h0) begin
         byte_valid_d = 1'b1;
      end
   end

   always_comb begin
      rdata_d = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            rx_bit_collision_pkg::comm_status_addr: begin
               rdata_d = {2'b00, cipher_q, 2'b00, comm_fsm_state};
            end
            rx_bit_collision_pkg::rx_bit_control_addr: begin
               rdata_d = ctrl_q;
            end
            rx_bit_collision_pkg::rx_collision_info_addr: begin
               rdata_d = {pos_valid_q, pos_q};
            end
            default: begin
               rdata_d = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cipher_q <= 1'b0;
         ctrl_q <= rx_bit_collision_pkg::rx_bit_control_reset;
         pos_q <= 7'h00;
         pos_valid_q <= 1'b0;
         clash_seen_q <= 1'b0;
         bit_idx_q <= 10'h000;
         byte_q <= 8'h00;
         byte_valid_q <= 1'b0;
         clash_flag_q <= 1'b0;
         integ_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         cipher_q <= cipher_d;
         ctrl_q <= ctrl_d;
         pos_q <= pos_d;
         pos_valid_q <= pos_valid_d;
         clash_seen_q <= clash_seen_d;
         bit_idx_q <= bit_idx_d;
         byte_q <= byte_d;
         byte_valid_q <= byte_valid_d;
         clash_flag_q <= clash_flag_d;
         integ_q <= integ_d;
         rdata_q <= rdata_d;
      end
   end

   // byte as it fills, so a partial last byte shows what arrived
   logic [7:0] out_byte_q;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         out_byte_q <= 8'h00;
      end else if (rx_bit_valid && !rx_start) begin
         out_byte_q <= {byte_q[7:0] & ~(8'h01 << slot)} | ({7'h00, data_bit} << slot);
      end
   end

   assign reg_rdata = rdata_q;
   assign cipher_active = cipher_q;
   assign rx_byte = out_byte_q;
   assign rx_byte_valid = byte_valid_q;
   assign clash_detected = clash_flag_q;
   assign integrity_error = integ_q;

   chk_cipher_write_one: assert property (@(posedge clk) disable iff (sys_rst)
      !card_authenticate_cmd && !cipher_q ##1 1'b1 |-> !cipher_q)
      else $error("cipher set without authenticate");
   chk_cipher_clear: assert property (@(posedge clk) disable iff (sys_rst)
      wr_status && !reg_wdata[5] && !card_authenticate_cmd |=> !cipher_q)
      else $error("cipher not cleared by write");
   chk_state_code: assert property (@(posedge clk) disable iff (sys_rst)
      $past(reg_rd) && $past(reg_addr) == 8'h0b |-> reg_rdata[2:0] != 3'b100)
      else $error("state code 100 seen");
   chk_pos_range: assert property (@(posedge clk) disable iff (sys_rst)
      pos_valid_q |-> pos_q <= 7'h3f)
      else $error("position beyond range");
   chk_pos_clear: assert property (@(posedge clk) disable iff (sys_rst)
      rx_start |=> !pos_valid_q && pos_q == 7'h00)
      else $error("position not cleared");
   chk_last_clear: assert property (@(posedge clk) disable iff (sys_rst)
      rx_start |=> ctrl_q[2:0] == 3'h0)
      else $error("last bits not cleared");
   chk_clash_flag: assert property (@(posedge clk) disable iff (sys_rst)
      rx_bit_valid && rx_bit_clash && !rx_start |=> clash_flag_q)
      else $error("collision flag missing");
   chk_integ_flag: assert property (@(posedge clk) disable iff (sys_rst)
      rx_bit_valid && rx_bit_clash && ctrl_q[3] && !rx_start |=> integ_q)
      else $error("integrity flag missing");
   chk_first_pos: assert property (@(posedge clk) disable iff (sys_rst)
      rx_bit_valid && rx_bit_clash && !clash_seen_q && !rx_start &&
      bit_idx_q < 10'd64 |=> pos_valid_q && pos_q == $past(bit_idx_q[6:0]))
      else $error("first position wrong");
   chk_zero_after: assert property (@(posedge clk) disable iff (sys_rst)
      rx_bit_valid && !rx_start && clash_seen_q && !ctrl_q[7]
      |=> !rx_byte[$past(slot)])
      else $error("bit after collision not zeroed");
   chk_byte_full: assert property (@(posedge clk) disable iff (sys_rst)
      rx_bit_valid && !rx_start && slot == 3'h7 |=> rx_byte_valid)
      else $error("full byte not presented");
   chk_last_bits: assert property (@(posedge clk) disable iff (sys_rst)
      rx_end && !rx_start && !rx_bit_valid && align != 3'h0
      |=> ctrl_q[2:0] == $past(slot))
      else $error("last bits not written");
   chk_byte_mode: assert property (@(posedge clk) disable iff (sys_rst)
      rx_end && !rx_start && align == 3'h0 |=> $stable(ctrl_q[2:0]))
      else $error("last bits written in byte mode");
   chk_valid_clash: assert property (@(posedge clk) disable iff (sys_rst)
      !clash_seen_q |-> !pos_valid_q)
      else $error("position valid without collision");
   chk_read_idle: assert property (@(posedge clk) disable iff (sys_rst)
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   cov_clash: cover property (@(posedge clk) rx_bit_valid && rx_bit_clash);
   cov_align_seven: cover property (@(posedge clk) rx_start && align == 3'h7);
   cov_out_range: cover property (@(posedge clk)
      rx_bit_valid && rx_bit_clash && bit_idx_q > 10'd63);
   cov_auth: cover property (@(posedge clk) card_authenticate_cmd);
   cov_byte: cover property (@(posedge clk) byte_valid_q);
endmodule // rx_bit_collision_status

/* File: test/card_model.sv */
// card side model: streams data bits with an optional collision
// assumes the bench waits for each frame task to return
`timescale 1ns/1ns
module card_model (
   // clock
   input wire logic clk,
   // frame signals toward the receiver
   output logic rx_start,
   output logic rx_bit_valid,
   output logic rx_bit,
   output logic rx_bit_clash,
   output logic rx_end
);
   initial begin
      {rx_start, rx_bit_valid, rx_bit, rx_bit_clash, rx_end} = 5'h00;
   end
   // n bits of value v, collision on bit c, g extra idle cycles per bit
   task automatic frame(input int n, input int c, input logic v, input int g);
      @(posedge clk) rx_start <= 1'b1;
      @(posedge clk) rx_start <= 1'b0;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         rx_bit_valid <= 1'b1;
         rx_bit <= (i == c) ? 1'b0 : v;
         rx_bit_clash <= (i == c);
         repeat (g + 1) begin
            @(posedge clk);
            rx_bit_valid <= 1'b0;
            rx_bit_clash <= 1'b0;
            // undriven between bits, so invert the level on each idle cycle
            rx_bit <= ~rx_bit;
         end
      end
      rx_end <= 1'b1;
      @(posedge clk) rx_end <= 1'b0;
   endtask
endmodule // card_model

/* File: test/rx_bit_collision_status_test.sv */
// self-checking bench for the receive bit control and collision registers
// assumes card_model feeds the framing inputs
`timescale 1ns/1ns
module rx_bit_collision_status_test;
   logic clk, sys_rst, reg_wr, reg_rd, card_authenticate_cmd, rx_start;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_byte, v;
   logic [2:0] comm_fsm_state;
   logic rx_bit_valid, rx_bit, rx_bit_clash, rx_end, cipher_active;
   logic rx_byte_valid, clash_detected, integrity_error;
   logic [7:0] bq[$];
   logic [2:0] codes[6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
   int mismatches = 0;
   int checks_done = 0;
   rx_bit_collision_status rx_bit_collision_status_inst (.clk(clk),
      .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .comm_fsm_state(comm_fsm_state), .rx_start(rx_start),
      .card_authenticate_cmd(card_authenticate_cmd), .rx_bit(rx_bit),
      .rx_bit_valid(rx_bit_valid), .rx_bit_clash(rx_bit_clash),
      .rx_end(rx_end), .cipher_active(cipher_active), .rx_byte(rx_byte),
      .rx_byte_valid(rx_byte_valid), .clash_detected(clash_detected),
      .integrity_error(integrity_error));
   card_model card_model_inst (.clk(clk), .rx_start(rx_start),
      .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
      .rx_bit_clash(rx_bit_clash), .rx_end(rx_end));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) if (rx_byte_valid === 1'b1) bq.push_back(rx_byte);
   task automatic cmp(input string w, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", w, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clk) reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string w);
      @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clk) reg_rd <= 1'b0;
      #1 cmp(w, e, reg_rdata);
   endtask
   task automatic cipher_and_state();
      foreach (codes[i]) begin
         comm_fsm_state <= codes[i];
         rd(8'h0b, {5'h00, codes[i]}, "state");
      end
      @(posedge clk) card_authenticate_cmd <= 1'b1;
      @(posedge clk) card_authenticate_cmd <= 1'b0;
      rd(8'h0b, 8'h27, "cipher on");
      wr(8'h0b, 8'h00);
      rd(8'h0b, 8'h07, "cipher off");
      wr(8'h0b, 8'hff);
      rd(8'h0b, 8'h07, "cipher sw set");
      cmp("cipher pin", 8'h00, {7'h00, cipher_active});
   endtask
   task automatic aligned_clash();
      wr(8'h0c, 8'h48);
      bq.delete();
      card_model_inst.frame(6, 3, 1'b1, 0);
      repeat (3) @(posedge clk);
      rd(8'h0d, 8'h87, "clash pos");
      cmp("flags", 8'h03, {6'h00, clash_detected, integrity_error});
      rd(8'h0c, 8'h4a, "last bits");
      cmp("bytes", 8'h02, 8'(bq.size()));
      cmp("byte0", 8'h70, bq[0]);
      cmp("byte1", 8'h00, bq[1]);
   endtask
   task automatic align_seven();
      wr(8'h0c, 8'hf0);
      bq.delete();
      card_model_inst.frame(3, -1, 1'b1, 2);
      repeat (3) @(posedge clk);
      cmp("byte0", 8'h80, bq[0]);
      cmp("byte1", 8'h03, bq[1]);
      rd(8'h0c, 8'hf2, "last bits");
      rd(8'h0d, 8'h00, "stale pos");
      cmp("flags", 8'h00, {6'h00, clash_detected, integrity_error});
   endtask
   task automatic range_edge();
      wr(8'h0c, 8'h80);
      bq.delete();
      card_model_inst.frame(64, 63, 1'b1, 0);
      repeat (3) @(posedge clk);
      rd(8'h0d, 8'hbf, "pos 3f");
      rd(8'h0c, 8'h80, "byte mode");
      cmp("integrity", 8'h00, {7'h00, integrity_error});
      cmp("byte7", 8'h7f, bq[7]);
      card_model_inst.frame(65, 64, 1'b1, 0);
      repeat (3) @(posedge clk);
      rd(8'h0d, 8'h00, "out of range");
      wr(8'h0d, 8'hff);
      rd(8'h0d, 8'h00, "read only");
      rd(8'h0e, 8'h00, "unmapped");
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      {sys_rst, reg_wr, reg_rd, card_authenticate_cmd} = 4'hf;
      {reg_rd, reg_wr, card_authenticate_cmd} = 3'h0;
      {reg_addr, reg_wdata, comm_fsm_state} = 19'h00000;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      rd(8'h0c, rx_bit_collision_pkg::rx_bit_control_reset, "ctrl reset");
      cipher_and_state();
      aligned_clash();
      align_seven();
      range_edge();
      wrap_up();
   end
   initial begin
      #200000 mismatches++;
      wrap_up();
   end
endmodule // rx_bit_collision_status_test
